// >>> rtl/rbsc_map.svh
`ifndef RBSC_MAP_SVH
`define RBSC_MAP_SVH
// Contract
// (R1) hold reset after power-on until 65,536 oscillator clocks are counted
// (R2) start the delay count only once the oscillator input reads high
// (R3) capture bus-mode strap only at power-on reset, ignore later changes
// (R4) strap 0 selects multiplexed bus, strap 1 demultiplexed bus
// (R5) muxed mode: latch strobe pulses 1.5 oscillator cycles, every four cycles; code holds it high 2 clocks
// (R6) demuxed mode: latch strobe toggles continuously while disable bit clear
// (R7) latch strobe high in reset, or when disabled in demuxed mode
// (R8) program-store strobe pulses low per external access, else held high; code pulses it only for external code fetches
// (R9) external code select low fetches external memory, high internal ROM
// (R10) high reset input requests reset; wired-OR sources, default low
// (R11) reset output low on pin, warm-up, watchdog, enabled osc-fail, low supply
// (R12) muxed mode: port 0 carries low address while strobe high, then data
// (R13) at terminal count release reset synchronously and stop counting
`define RBSC_POR_COUNT      17'h10000
`define RBSC_POR_ONE        17'h00001
`define RBSC_POR_ZERO       17'h00000
`define RBSC_PH_ZERO        2'h0
`define RBSC_PH_ONE         2'h1
`define RBSC_PH_LAST        2'h3
`define RBSC_MODE_MUXED     1'h0
`endif

// >>> rtl/rbsc_pkg.sv
package rbsc_pkg;
  typedef enum logic [1:0] {
    rbsc_st_wait_osc,
    rbsc_st_count,
    rbsc_st_run
  } rbsc_state_type;

  typedef struct packed {
    logic       req;
    logic [7:0] addr_lo;
    logic [7:0] wdata;
    logic       write;
  } rbsc_access_type;
endpackage

// >>> rtl/rbsc_sync3.sv
`timescale 1ns/10ps
module rbsc_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  // ==========================================
  // three stages, change taken once the last two agree
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (agree & s3_q) | (~agree & dout);
    end
  end
endmodule

// >>> rtl/rbsc_top.sv
`timescale 1ns/10ps
`include "rbsc_map.svh"
module rbsc_top #(
  parameter int POR_CLOCKS = `RBSC_POR_COUNT
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     osc_input,
  input  wire logic                     ext_reset_req,
  input  wire logic                     wdt_reset,
  input  wire logic                     osc_fail,
  input  wire logic                     osc_fail_reset_enable,
  input  wire logic                     supply_low,
  input  wire logic                     stop_exit,
  input  wire logic                     bus_mode_select_n,
  input  wire logic                     external_code_select_n,
  input  wire logic                     latch_strobe_disable,
  input  wire rbsc_pkg::rbsc_access_type access,
  input  wire logic                     access_is_code,
  output logic                          core_reset,
  output logic                          reset_out_n,
  output logic                          code_from_external,
  output logic                          demuxed_mode,
  output logic                          ale,
  output logic                          program_store_strobe_n,
  output logic                 [7:0]    muxed_addr_data_bus_o,
  output logic                          muxed_addr_data_bus_oe_n,
  output logic                          access_done
);
  import rbsc_pkg::*;

  // ==========================================
  // parameter check
  if (POR_CLOCKS < 1 || POR_CLOCKS > `RBSC_POR_COUNT) begin : g_por_range
    $error("POR_CLOCKS out of range");
  end

  // ==========================================
  // pin synchronisers
  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  logic       osc_s;
  logic       pin_rst_s;
  logic       mode_s;
  logic       ext_code_s;
  logic       lsd_s;

  assign pins_raw  = {latch_strobe_disable, external_code_select_n, bus_mode_select_n, ext_reset_req, osc_input};
  assign osc_s     = pins_s[0];
  assign pin_rst_s = pins_s[1];
  assign mode_s    = pins_s[2];
  assign ext_code_s = pins_s[3];
  assign lsd_s     = pins_s[4];

  rbsc_sync3 #(.WIDTH(5)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (pins_raw),
    .dout (pins_s)
  );

  // ==========================================
  // power-on delay
  rbsc_state_type state_q;
  rbsc_state_type state_d;
  logic [16:0]    por_cnt_q;
  logic [16:0]    por_limit;
  logic           por_done;
  logic           mode_q;
  logic           warmup;
  logic           any_reset;

  assign por_limit = 17'(POR_CLOCKS);
  assign por_done  = (state_q == rbsc_st_count) && (por_cnt_q == por_limit - `RBSC_POR_ONE); // R1
  assign warmup    = (state_q != rbsc_st_run);
  // osc-fail only counts when enabled; low supply always does
  assign any_reset = warmup | pin_rst_s | wdt_reset | (osc_fail & osc_fail_reset_enable) | supply_low; // R10 R11

  // stop_exit reruns warm-up but leaves the strap capture closed
  always_comb begin
    state_d = state_q;
    case (state_q)
      rbsc_st_wait_osc: if (osc_s) state_d = rbsc_st_count;   // R2
      rbsc_st_count:    if (por_done) state_d = rbsc_st_run;  // R13
      rbsc_st_run:      if (stop_exit) state_d = rbsc_st_wait_osc;
      default:          state_d = rbsc_st_wait_osc;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= rbsc_st_wait_osc;
      por_cnt_q <= `RBSC_POR_ZERO;
    end else begin
      state_q   <= state_d;
      por_cnt_q <= (state_q == rbsc_st_count && !por_done) ? por_cnt_q + `RBSC_POR_ONE : `RBSC_POR_ZERO; // R1 R13
    end
  end

  // strap caught only during power-on warm-up, not on stop exit
  logic por_phase_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      por_phase_q <= 1'b1;
      mode_q      <= `RBSC_MODE_MUXED;
    end else begin
      if (state_q == rbsc_st_run) por_phase_q <= 1'b0;
      if (por_phase_q) mode_q <= mode_s; // R3
    end
  end

  // ==========================================
  // strobe phase: 4 clocks per bus cycle
  logic [1:0] ph_q;
  logic       muxed;
  logic       ale_d;
  logic       store_n_d;
  logic       cyc_start;
  logic       acc_q;
  logic       acc_code_q;
  logic [7:0] addr_q;
  logic [7:0] wdat_q;
  logic       wr_q;
  logic       oe_n_d;
  logic [7:0] bus_d;

  assign muxed     = (mode_q == `RBSC_MODE_MUXED); // R4
  assign cyc_start = (ph_q == `RBSC_PH_ZERO);
  // mclk stands in for osc; half-cycle tail rounds up to 2 clocks
  assign ale_d  = any_reset ? 1'b1 :                        // R7
                  muxed ? (ph_q == `RBSC_PH_ZERO || ph_q == `RBSC_PH_ONE) : // R5
                  (lsd_s ? 1'b1 : ph_q[0]);                 // R6 R7
  assign store_n_d = !(acc_q && acc_code_q && !any_reset && ph_q != `RBSC_PH_ZERO); // R8
  // address leaves on the take edge so it stands for the whole high strobe
  assign oe_n_d    = !(!any_reset && muxed &&
                       (cyc_start ? access.req : (acc_q && (ph_q == `RBSC_PH_ONE || wr_q)))); // R12
  assign bus_d     = cyc_start ? access.addr_lo : ((ph_q == `RBSC_PH_ONE) ? addr_q : wdat_q); // R12

  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q       <= `RBSC_PH_ZERO;
      acc_q      <= 1'b0;
      acc_code_q <= 1'b0;
      addr_q     <= 8'h00;
      wdat_q     <= 8'h00;
      wr_q       <= 1'b0;
    end else begin
      ph_q <= any_reset ? `RBSC_PH_ZERO : ph_q + `RBSC_PH_ONE;
      if (cyc_start) begin
        acc_q      <= access.req && !any_reset;
        acc_code_q <= access_is_code && ext_code_s == 1'b0; // R9
        addr_q     <= access.addr_lo;
        wdat_q     <= access.wdata;
        wr_q       <= access.write;
      end
    end
  end

  // ==========================================
  // output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_reset               <= 1'b1;
      reset_out_n              <= 1'b0;
      code_from_external       <= 1'b0;
      demuxed_mode             <= 1'b0;
      ale                      <= 1'b1;
      program_store_strobe_n   <= 1'b1;
      muxed_addr_data_bus_o    <= 8'h00;
      muxed_addr_data_bus_oe_n <= 1'b1;
      access_done              <= 1'b0;
    end else begin
      core_reset               <= any_reset;   // R11
      reset_out_n              <= !any_reset;  // R11 R13
      code_from_external       <= !ext_code_s; // R9
      demuxed_mode             <= !muxed;
      ale                      <= ale_d;
      program_store_strobe_n   <= store_n_d;
      muxed_addr_data_bus_o    <= bus_d;
      muxed_addr_data_bus_oe_n <= oe_n_d;
      access_done              <= acc_q && (ph_q == `RBSC_PH_LAST) && !any_reset;
    end
  end

  // ==========================================
  // checks
  a_reset_out_low: assert property (@(posedge mclk) disable iff (rst) // R11
    any_reset |=> !reset_out_n) else $error("reset out not low");
  a_ale_reset_high: assert property (@(posedge mclk) disable iff (rst) // R7
    any_reset |=> ale) else $error("latch strobe not high in reset");
  a_store_idle_high: assert property (@(posedge mclk) disable iff (rst) // R8
    !acc_q |=> program_store_strobe_n) else $error("store strobe low idle");
  a_store_code_only: assert property (@(posedge mclk) disable iff (rst) // R8 R9
    $fell(program_store_strobe_n) |-> $past(acc_q && acc_code_q)) else $error("store strobe without code fetch");
  a_mode_held: assert property (@(posedge mclk) disable iff (rst) // R3
    !por_phase_q |=> $stable(mode_q)) else $error("strap changed after por");
  // looks back three cycles so the whole high-high-low-low window is judged at once
  a_ale_period: assert property (@(posedge mclk) disable iff (rst) // R5
    (muxed && !any_reset && ph_q == `RBSC_PH_ZERO) ##1 (muxed && !any_reset) [*3]
      |=> $past(ale, 3) && $past(ale, 2) && !$past(ale) && !ale) else $error("latch strobe pulse shape");
  a_addr_held: assert property (@(posedge mclk) disable iff (rst) // R12
    ale && $past(ale) && !muxed_addr_data_bus_oe_n && !$past(muxed_addr_data_bus_oe_n)
      |-> $stable(muxed_addr_data_bus_o)) else $error("address moved under latch strobe");
  a_demux_toggle: assert property (@(posedge mclk) disable iff (rst) // R6
    (!muxed && !lsd_s && !any_reset) [*2] |=> ale != $past(ale)) else $error("demuxed strobe not toggling");
  a_ale_off_demux: assert property (@(posedge mclk) disable iff (rst) // R7
    (!muxed && lsd_s) |=> ale) else $error("disabled strobe not high");
  a_wait_osc: assert property (@(posedge mclk) disable iff (rst) // R2
    (state_q == rbsc_st_wait_osc && !osc_s) |=> state_q != rbsc_st_count) else $error("count before osc");
  a_count_done: assert property (@(posedge mclk) disable iff (rst) // R13
    por_done |=> state_q == rbsc_st_run ##1 (reset_out_n || $past(any_reset))) else $error("no release");
  a_cnt_stop: assert property (@(posedge mclk) disable iff (rst) // R1
    state_q == rbsc_st_run |-> por_cnt_q == `RBSC_POR_ZERO) else $error("counter running");

  // ==========================================
  // coverage
  c_release: cover property (@(posedge mclk) disable iff (rst) $rose(reset_out_n));
  c_store_pulse: cover property (@(posedge mclk) disable iff (rst) $fell(program_store_strobe_n));
  c_demux: cover property (@(posedge mclk) disable iff (rst) demuxed_mode && $fell(ale));
  c_write_data: cover property (@(posedge mclk) disable iff (rst) acc_q && wr_q && !ale && !muxed_addr_data_bus_oe_n);
  c_stop_restart: cover property (@(posedge mclk) disable iff (rst) stop_exit && state_q == rbsc_st_run);
endmodule

// >>> test/rbsc_mem_model.sv
`timescale 1ns/10ps
// ==========
// external address latch and memory
module rbsc_mem_model (
  input  wire logic       mclk,
  input  wire logic       ale,
  input  wire logic       program_store_strobe_n,
  input  wire logic [7:0] bus,
  input  wire logic       bus_oe_n,
  output logic      [7:0] addr_q,
  output logic      [7:0] data_q,
  output logic            store_seen_q
);
  logic ale_q;
  // chip enable wins over the new-cycle clear, both can meet in one cycle
  always_ff @(posedge mclk) begin
    ale_q <= ale;
    if (!program_store_strobe_n) store_seen_q <= 1'b1;
    else if (ale && !ale_q) store_seen_q <= 1'b0;
    if (ale && !bus_oe_n) addr_q <= bus;
    else if (!bus_oe_n) data_q <= bus;
  end
endmodule

// >>> test/reset_and_bus_strobe_control_tb.sv
`timescale 1ns/10ps
module reset_and_bus_strobe_control_tb;
  import rbsc_pkg::*;
  localparam int POR = 16;
  logic mclk = 0, rst = 1, osc = 0, ext_rq = 0, wdt = 0, ofail = 0, ofen = 0, slow = 0, stopx = 0;
  logic strap_n = 0, ext_n = 0, lsd = 0, is_code = 0, a0;
  rbsc_access_type acc = '0;
  logic core_reset, reset_out_n, code_ext, demux, ale, store_n, oe_n, done, m_store;
  logic [7:0] bus_o, m_addr, m_data, s;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int bad_count = 0, checked = 0, cyc = 0;
  rbsc_top #(.POR_CLOCKS(POR)) i_dut (.mclk(mclk), .rst(rst), .osc_input(osc), .ext_reset_req(ext_rq),
    .wdt_reset(wdt), .osc_fail(ofail), .osc_fail_reset_enable(ofen), .supply_low(slow), .stop_exit(stopx),
    .bus_mode_select_n(strap_n), .external_code_select_n(ext_n), .latch_strobe_disable(lsd), .access(acc),
    .access_is_code(is_code), .core_reset(core_reset), .reset_out_n(reset_out_n), .code_from_external(code_ext),
    .demuxed_mode(demux), .ale(ale), .program_store_strobe_n(store_n), .muxed_addr_data_bus_o(bus_o),
    .muxed_addr_data_bus_oe_n(oe_n), .access_done(done));
  rbsc_mem_model i_mem (.mclk(mclk), .ale(ale), .program_store_strobe_n(store_n), .bus(bus_o),
    .bus_oe_n(oe_n), .addr_q(m_addr), .data_q(m_data), .store_seen_q(m_store));
  // ==========
  // helpers
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rel();
    repeat (POR + 30) if (reset_out_n !== 1'b1) tick(1);
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // req stays up between calls so cycles run back to back
  task automatic bus_cycle(logic w, logic code);
    logic [7:0] a, d;
    a = 8'($urandom);
    d = 8'($urandom);
    acc = '{req: 1'b1, addr_lo: a, wdata: d, write: w};
    is_code = code;
    exp_q.push_back({w, code & ~ext_n, a, d});
    @(posedge ale);
    #1;
  endtask
  task automatic run_group();
    for (int i = 0; i < 4; i++) bus_cycle(i[0], i[1]);
    acc.req = 1'b0;
    wait (exp_q.size() == 0);
    tick(4);
  endtask
  // ==========
  // result watcher
  always @(posedge mclk) if (done === 1'b1) begin
    if (exp_q.size() == 0) chk("spare done", 18'h0, 18'h1);
    else begin
      e = exp_q.pop_front();
      chk("access", e, {e[17], m_store, m_addr, e[17] ? m_data : e[7:0]});
    end
  end
  // ==========
  // sequence
  initial begin
    void'($urandom(32'h2E86));
    tick(5);
    chk("in reset", 18'h6, {ale, store_n, reset_out_n});
    rst = 0;
    tick(40);
    chk("osc low", 18'h0, reset_out_n);
    osc = 1;
    tick(POR);
    chk("counting", 18'h0, reset_out_n);
    rel();
    chk("released", 18'h1, reset_out_n);
    strap_n = 1;
    tick(6);
    chk("strap", 18'h0, demux);
    for (int i = 0; i < 8; i++) begin
      s[i] = ale;
      tick(1);
    end
    chk("ale shape", {10'h0, s[3:0], 4'h2}, {10'h0, s[7:4], 4'($countones(s[3:0]))});
    run_group();
    ext_n = 1;
    tick(6);
    chk("code src", 18'h0, code_ext);
    run_group();
    for (int i = 0; i < 5; i++) begin
      ofen = 1;
      {ext_rq, wdt, ofail, slow, stopx} = 5'h10 >> i;
      tick(1);
      stopx = 0;
      tick(5);
      chk("source", 18'h1, {reset_out_n, ale});
      {ext_rq, wdt, ofail, slow} = 4'h0;
      rel();
      chk("recover", 18'h1, reset_out_n);
    end
    chk("strap kept", 18'h0, demux);
    ofen = 0;
    ofail = 1;
    tick(8);
    chk("fail masked", 18'h1, reset_out_n);
    ofail = 0;
    rst = 1;
    tick(5);
    rst = 0;
    rel();
    chk("demux", 18'h1, demux);
    a0 = ale;
    tick(1);
    chk("toggle", {17'h0, ~a0}, ale);
    lsd = 1;
    tick(6);
    for (int i = 0; i < 4; i++) begin
      chk("ale off", 18'h1, ale);
      tick(1);
    end
    close_out();
  end
endmodule
